// ### hdl/rdw_pkg.sv
/*
 * Shared constants for the receive descriptor write-back path: memory
 * layout of frame and buffer descriptors, status bit positions, control
 * block location and the host register map.
 * Assumes 16-bit shared memory words, little-endian byte lanes.
 */
package rdw_pkg;
    // Receive unit state reported to the host
    typedef enum logic [1:0] {
        RU_IDLE,
        RU_SUSPENDED,
        RU_NO_RESOURCES,
        RU_READY
    } rdw_ru_state_t;

    // Frame descriptor word indexes
    localparam logic [3:0] FD_STATUS_IDX = 4'h0;
    localparam logic [3:0] FD_CMD_IDX = 4'h1;
    localparam logic [3:0] FD_LINK_IDX = 4'h2;
    localparam logic [3:0] FD_RBD_IDX = 4'h3;
    localparam logic [3:0] FD_DST_IDX = 4'h4;

    // Frame descriptor status and command bits
    localparam int FD_C_BIT = 15;
    localparam int FD_B_BIT = 14;
    localparam int FD_OK_BIT = 13;
    localparam int FD_CRC_BIT = 11;
    localparam int FD_ALIGN_BIT = 10;
    localparam int FD_RES_BIT = 9;
    localparam int FD_OVR_BIT = 8;
    localparam int FD_SHORT_BIT = 7;
    localparam int FD_NOEND_BIT = 6;
    localparam int FD_EL_BIT = 15;
    localparam int FD_S_BIT = 14;

    // Buffer descriptor word indexes
    localparam logic [3:0] RBD_STATUS_IDX = 4'h0;
    localparam logic [3:0] RBD_NEXT_IDX = 4'h1;
    localparam logic [3:0] RBD_ADRLO_IDX = 4'h2;
    localparam logic [3:0] RBD_ADRHI_IDX = 4'h3;
    localparam logic [3:0] RBD_SIZE_IDX = 4'h4;

    // Buffer descriptor bits
    localparam int RBD_EOF_BIT = 15;
    localparam int RBD_F_BIT = 14;
    localparam int RBD_EL_BIT = 15;
    localparam int COUNT_W = 14;

    // Offset meaning no buffer attached
    localparam logic [15:0] NO_RBD = 16'hffff;

    // Control block byte address and receive area offset word
    localparam logic [15:0] SCB_BASE = 16'h0000;
    localparam logic [3:0] SCB_RFA_IDX = 4'h3;

    // Host register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MADDR = 8'h08;
    localparam logic [7:0] REG_MDATA = 8'h0c;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_RESUME_BIT = 1;
endpackage

// ### hdl/rdw_link_if.sv
/*
 * Link between the receive unit and the host side: a word memory port
 * into shared memory plus receive unit start, resume and state.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface rdw_link_if;
    logic mem_req;
    logic mem_we;
    logic [23:0] mem_addr;
    logic [1:0] mem_be;
    logic [15:0] mem_wdata;
    logic mem_ack;
    logic [15:0] mem_rdata;
    logic ru_start;
    logic ru_resume;
    rdw_pkg::rdw_ru_state_t ru_state;

    modport dev (
        output mem_req, mem_we, mem_addr, mem_be, mem_wdata, ru_state,
        input mem_ack, mem_rdata, ru_start, ru_resume
    );
    modport host (
        input mem_req, mem_we, mem_addr, mem_be, mem_wdata, ru_state,
        output mem_ack, mem_rdata, ru_start, ru_resume
    );
endinterface

// ### hdl/rdw_dev.sv
/*
 * Receive unit: takes received frame bytes, walks the frame descriptor
 * list and the buffer descriptor chain in shared memory and writes back
 * addresses, byte counts and status.
 * Assumes a memory port that holds each request until a one-cycle ack,
 * and a byte source on the same clock.
 */
// Functional notes
// - Set consumed bit, then completed bit
// - OK bit set only when no error
// - Report crc, alignment, resources, overrun, short
// - Missing end flag only under bit stuffing
// - End-of-list command stops the receive list
// - Suspend command halts after this frame
// - Next frame descriptor via link offset
// - All-ones buffer offset means no buffers
// - Host seeds buffer offset; unit rewrites it
// - Destination address written, configured length
// - Source address written, same length
// - Two-byte length field written
// - Last buffer of frame flagged
// - Occupied byte count with valid bit
// - Follow next buffer descriptor offset
// - 24-bit absolute buffer address used
// - Honour buffer size and last-buffer flag
// - First frame descriptor from control block
`timescale 1ns/100ps
module rdw_dev #(
    parameter int ADDR_LEN = 6
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Shared memory and control link
    rdw_link_if.dev link,
    // Received byte stream
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_last_i,
    output logic rx_ready_o,
    // Frame error indications, sampled with every byte
    input wire logic rx_crc_err_i,
    input wire logic rx_align_err_i,
    input wire logic rx_overrun_i,
    input wire logic rx_short_i,
    input wire logic rx_no_end_i,
    input wire logic cfg_bitstuff_i
);
    localparam logic [4:0] HDR_BYTES = 5'(2 * ADDR_LEN + 2);

    typedef enum logic [3:0] {
        S_IDLE, S_SCB, S_FD_RD, S_FD_BUSY, S_RXB, S_HDR_WR, S_PLACE,
        S_RBD_RD, S_RBD_FULL, S_DAT_WR, S_FIN_RBD, S_FIN_FD3, S_FIN_FD0,
        S_SUSP
    } rdw_dev_state_t;

    rdw_dev_state_t state_r;
    logic [2:0] idx_r;
    logic [15:0] fd_r, link_r, rbd_r, next_r, first_rbd_r;
    logic el_r, susp_r;
    logic have_r, loaded_r, rbd_el_r, used_r;
    logic [23:0] buf_r;
    logic [13:0] size_r, cnt_r;
    logic [4:0] hdr_r;
    logic [7:0] byte_r;
    logic last_r;
    logic crc_r, align_r, res_r, ovr_r, short_r, noend_r;
    logic ack;
    logic take;
    logic [15:0] fstat;
    logic [23:0] dat_addr;

    // Word address inside a descriptor
    function automatic logic [23:0] waddr(input logic [15:0] base,
                                          input logic [3:0] idx);
        waddr = {8'h00, base} + {19'h0, idx, 1'b0};
    endfunction

    assign ack = link.mem_ack;
    assign take = rx_valid_i && rx_ready_o;
    assign rx_ready_o = (state_r == S_RXB);
    assign dat_addr = buf_r + {10'h0, cnt_r};

    // Frame status word, errors only when not OK
    always_comb begin
        fstat = 16'h0;
        fstat[rdw_pkg::FD_C_BIT] = 1'b1;
        fstat[rdw_pkg::FD_B_BIT] = 1'b1;
        fstat[rdw_pkg::FD_CRC_BIT] = crc_r;
        fstat[rdw_pkg::FD_ALIGN_BIT] = align_r;
        fstat[rdw_pkg::FD_RES_BIT] = res_r;
        fstat[rdw_pkg::FD_OVR_BIT] = ovr_r;
        fstat[rdw_pkg::FD_SHORT_BIT] = short_r;
        fstat[rdw_pkg::FD_NOEND_BIT] = noend_r;
        fstat[rdw_pkg::FD_OK_BIT] = ~(crc_r | align_r | res_r | ovr_r |
                                      short_r | noend_r);
    end

    // Memory request drive per state
    always_comb begin
        link.mem_req = 1'b0;
        link.mem_we = 1'b0;
        link.mem_addr = 24'h0;
        link.mem_be = 2'b11;
        link.mem_wdata = 16'h0;
        unique case (state_r)
            S_SCB: begin
                link.mem_req = 1'b1;
                link.mem_addr = waddr(rdw_pkg::SCB_BASE,
                                      rdw_pkg::SCB_RFA_IDX);
            end
            S_FD_RD: begin
                link.mem_req = 1'b1;
                link.mem_addr = waddr(fd_r, {1'b0, idx_r});
            end
            S_FD_BUSY: begin
                link.mem_req = 1'b1;
                link.mem_we = 1'b1;
                link.mem_addr = waddr(fd_r, rdw_pkg::FD_STATUS_IDX);
                link.mem_wdata[rdw_pkg::FD_B_BIT] = 1'b1;
            end
            S_HDR_WR: begin
                // Destination, source, then length field
                link.mem_req = 1'b1;
                link.mem_we = 1'b1;
                // Odd header bytes carry their byte address bit
                link.mem_addr = waddr(fd_r, rdw_pkg::FD_DST_IDX +
                                      hdr_r[4:1]) | 24'(hdr_r[0]);
                link.mem_be = hdr_r[0] ? 2'b10 : 2'b01;
                link.mem_wdata = {byte_r, byte_r};
            end
            S_RBD_RD: begin
                link.mem_req = 1'b1;
                link.mem_addr = waddr(rbd_r, {1'b0, idx_r});
            end
            S_DAT_WR: begin
                link.mem_req = 1'b1;
                link.mem_we = 1'b1;
                link.mem_addr = dat_addr;
                link.mem_be = dat_addr[0] ? 2'b10 : 2'b01;
                link.mem_wdata = {byte_r, byte_r};
            end
            S_RBD_FULL, S_FIN_RBD: begin
                link.mem_req = (state_r == S_RBD_FULL) || loaded_r;
                link.mem_we = 1'b1;
                link.mem_addr = waddr(rbd_r, rdw_pkg::RBD_STATUS_IDX);
                link.mem_wdata = {(state_r == S_FIN_RBD), 1'b1,
                                  cnt_r};
            end
            S_FIN_FD3: begin
                link.mem_req = 1'b1;
                link.mem_we = 1'b1;
                link.mem_addr = waddr(fd_r, rdw_pkg::FD_RBD_IDX);
                link.mem_wdata = used_r ? first_rbd_r
                                        : rdw_pkg::NO_RBD;
            end
            S_FIN_FD0: begin
                link.mem_req = 1'b1;
                link.mem_we = 1'b1;
                link.mem_addr = waddr(fd_r, rdw_pkg::FD_STATUS_IDX);
                link.mem_wdata = fstat;
            end
            default: ;
        endcase
    end

    // Receive unit state for the host
    always_comb begin
        unique case (state_r)
            S_IDLE: link.ru_state = rdw_pkg::RU_IDLE;
            S_SUSP: link.ru_state = rdw_pkg::RU_SUSPENDED;
            default: link.ru_state = have_r ? rdw_pkg::RU_READY
                                            : rdw_pkg::RU_NO_RESOURCES;
        endcase
    end

    // Main sequencer
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_r <= S_IDLE;
            idx_r <= 3'h0;
            fd_r <= 16'h0;
        end else begin
            unique case (state_r)
                S_IDLE: if (link.ru_start) state_r <= S_SCB;
                S_SCB: if (ack) begin
                    fd_r <= link.mem_rdata;
                    idx_r <= 3'h1;
                    state_r <= S_FD_RD;
                end
                S_FD_RD: if (ack) begin
                    idx_r <= idx_r + 3'h1;
                    if (idx_r == 3'h3) state_r <= S_FD_BUSY;
                end
                S_FD_BUSY: if (ack) state_r <= S_RXB;
                S_RXB: if (take) begin
                    state_r <= (hdr_r < HDR_BYTES) ? S_HDR_WR : S_PLACE;
                end
                S_HDR_WR, S_DAT_WR: if (ack) begin
                    state_r <= last_r ? S_FIN_RBD : S_RXB;
                end
                S_PLACE: begin
                    if (!have_r) begin
                        state_r <= last_r ? S_FIN_RBD : S_RXB;
                    end else if (!loaded_r) begin
                        idx_r <= 3'h1;
                        state_r <= S_RBD_RD;
                    end else if (cnt_r == size_r) begin
                        state_r <= S_RBD_FULL;
                    end else begin
                        state_r <= S_DAT_WR;
                    end
                end
                S_RBD_RD: if (ack) begin
                    idx_r <= idx_r + 3'h1;
                    if (idx_r == 3'h4) state_r <= S_PLACE;
                end
                S_RBD_FULL: if (ack) state_r <= S_PLACE;
                S_FIN_RBD: if (ack || !loaded_r) state_r <= S_FIN_FD3;
                S_FIN_FD3: if (ack) state_r <= S_FIN_FD0;
                S_FIN_FD0: if (ack) begin
                    idx_r <= 3'h1;
                    fd_r <= link_r;
                    if (susp_r) state_r <= S_SUSP;
                    else if (el_r) state_r <= S_IDLE;
                    else state_r <= S_FD_RD;
                end
                S_SUSP: if (link.ru_resume) begin
                    state_r <= el_r ? S_IDLE : S_FD_RD;
                end
            endcase
        end
    end

    // Frame descriptor command and link capture
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            el_r <= 1'b0;
            susp_r <= 1'b0;
            link_r <= 16'h0;
        end else if (state_r == S_FD_RD && ack) begin
            if (idx_r == 3'h1) begin
                el_r <= link.mem_rdata[rdw_pkg::FD_EL_BIT];
                susp_r <= link.mem_rdata[rdw_pkg::FD_S_BIT];
            end
            if (idx_r == 3'h2) link_r <= link.mem_rdata;
        end
    end

    // Buffer descriptor chain tracking
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            have_r <= 1'b0;
            loaded_r <= 1'b0;
            rbd_r <= 16'h0;
            next_r <= 16'h0;
            buf_r <= 24'h0;
            size_r <= 14'h0;
            rbd_el_r <= 1'b0;
            cnt_r <= 14'h0;
            first_rbd_r <= 16'h0;
            used_r <= 1'b0;
        end else begin
            if (state_r == S_FD_RD && ack && idx_r == 3'h3 && !have_r &&
                link.mem_rdata != rdw_pkg::NO_RBD) begin
                rbd_r <= link.mem_rdata;
                have_r <= 1'b1;
                loaded_r <= 1'b0;
            end
            if (state_r == S_FD_BUSY && ack) begin
                first_rbd_r <= rbd_r;
                used_r <= 1'b0;
            end
            if (state_r == S_RBD_RD && ack) begin
                unique case (idx_r)
                    3'h1: next_r <= link.mem_rdata;
                    3'h2: buf_r[15:0] <= link.mem_rdata;
                    3'h3: buf_r[23:16] <= link.mem_rdata[7:0];
                    default: begin
                        rbd_el_r <= link.mem_rdata[rdw_pkg::RBD_EL_BIT];
                        size_r <= link.mem_rdata[13:0];
                        cnt_r <= 14'h0;
                        loaded_r <= 1'b1;
                    end
                endcase
            end
            if (state_r == S_DAT_WR && ack) begin
                cnt_r <= cnt_r + 14'h1;
                used_r <= 1'b1;
            end
            // Move on after a full or final buffer
            if ((state_r == S_RBD_FULL && ack) ||
                (state_r == S_FIN_RBD && ack && loaded_r)) begin
                loaded_r <= 1'b0;
                if (rbd_el_r) have_r <= 1'b0;
                else rbd_r <= next_r;
            end
        end
    end

    // Byte capture, header index and error accumulation
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || (state_r == S_FD_BUSY && ack)) begin
            byte_r <= 8'h0;
            last_r <= 1'b0;
            hdr_r <= 5'h0;
            {crc_r, align_r, ovr_r, short_r, noend_r, res_r} <= 6'h0;
        end else begin
            if (take) begin
                byte_r <= rx_data_i;
                last_r <= rx_last_i;
                crc_r <= crc_r | rx_crc_err_i;
                align_r <= align_r | rx_align_err_i;
                ovr_r <= ovr_r | rx_overrun_i;
                short_r <= short_r | rx_short_i;
                noend_r <= noend_r | (rx_no_end_i & cfg_bitstuff_i);
            end
            if (state_r == S_HDR_WR && ack) hdr_r <= hdr_r + 5'h1;
            if ((state_r == S_PLACE && !have_r) ||
                (state_r == S_RBD_FULL && ack && rbd_el_r)) begin
                res_r <= 1'b1;
            end
        end
    end
endmodule

// ### hdl/rdw_host.sv
/*
 * Host end: shared memory of 16-bit words in flip-flops, served to the
 * receive unit, plus an APB slave for software to fill descriptors,
 * start and resume the receive unit and read its state.
 * Assumes one clock; the memory answers a request one cycle later.
 */
`timescale 1ns/100ps
module rdw_host #(
    parameter int DEPTH = 256
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Receive unit link
    rdw_link_if.host link,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    localparam int IW = $clog2(DEPTH);

    logic [15:0] mem_r [DEPTH];
    logic [IW-1:0] maddr_r, didx;
    logic ack_r, start_r, resume_r;
    logic [15:0] rdata_r;
    logic apb_wr, dev_go, mapped;

    assign apb_wr = psel_i && penable_i && pwrite_i;
    assign didx = link.mem_addr[IW:1];
    assign dev_go = link.mem_req && !ack_r;
    assign link.mem_ack = ack_r;
    assign link.mem_rdata = rdata_r;
    assign link.ru_start = start_r;
    assign link.ru_resume = resume_r;
    assign pready_o = 1'b1;
    assign mapped = paddr_i == rdw_pkg::REG_CTRL ||
                    paddr_i == rdw_pkg::REG_STATUS ||
                    paddr_i == rdw_pkg::REG_MADDR ||
                    paddr_i == rdw_pkg::REG_MDATA;
    assign pslverr_o = psel_i && penable_i && !mapped;

    // Read data mux
    always_comb begin
        prdata_o = 32'h0;
        if (paddr_i == rdw_pkg::REG_STATUS) begin
            prdata_o = {30'h0, link.ru_state};
        end else if (paddr_i == rdw_pkg::REG_MADDR) begin
            prdata_o = 32'(maddr_r);
        end else if (paddr_i == rdw_pkg::REG_MDATA) begin
            prdata_o = {16'h0, mem_r[maddr_r]};
        end
    end

    // Memory port answer, one cycle per request
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ack_r <= 1'b0;
            rdata_r <= 16'h0;
        end else begin
            ack_r <= dev_go;
            if (dev_go) rdata_r <= mem_r[didx];
        end
    end

    // Control pulses and memory index register
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            start_r <= 1'b0;
            resume_r <= 1'b0;
            maddr_r <= '0;
        end else begin
            start_r <= apb_wr && paddr_i == rdw_pkg::REG_CTRL &&
                       pwdata_i[rdw_pkg::CTRL_START_BIT];
            resume_r <= apb_wr && paddr_i == rdw_pkg::REG_CTRL &&
                        pwdata_i[rdw_pkg::CTRL_RESUME_BIT];
            if (apb_wr && paddr_i == rdw_pkg::REG_MADDR) begin
                maddr_r <= pwdata_i[IW-1:0];
            end
        end
    end

    // Shared memory, device byte writes after software writes
    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (apb_wr && paddr_i == rdw_pkg::REG_MDATA &&
                maddr_r == IW'(i)) begin
                mem_r[i] <= pwdata_i[15:0];
            end
            if (dev_go && link.mem_we && didx == IW'(i)) begin
                if (link.mem_be[0]) mem_r[i][7:0] <= link.mem_wdata[7:0];
                if (link.mem_be[1]) mem_r[i][15:8] <= link.mem_wdata[15:8];
            end
        end
    end
endmodule

// ### verification/rdw_properties.sv
/* Checker on the link between receive unit and host memory.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module rdw_properties (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Memory port
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic [1:0] mem_be,
    input wire logic [15:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // Unit control and state
    input wire logic ru_start,
    input wire logic ru_resume,
    input wire rdw_pkg::rdw_ru_state_t ru_state
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    // Request waiting for its answer
    sequence req_wait_s;
        mem_req && !mem_ack;
    endsequence
    // Request and qualifiers unchanged
    sequence req_held_s;
        mem_req && $stable(mem_addr) && $stable(mem_we) &&
            $stable(mem_be) && $stable(mem_wdata);
    endsequence
    // Unit parked after a suspend
    sequence parked_s;
        ru_state == rdw_pkg::RU_SUSPENDED;
    endsequence

    AST_REQ_HOLD: assert property (req_wait_s |=> req_held_s)
        else $error("memory request changed before its ack");
    AST_ACK_NEXT: assert property (req_wait_s |=> mem_ack)
        else $error("memory ack late");
    AST_ACK_PULSE: assert property (mem_ack |=> !mem_ack)
        else $error("memory ack longer than one cycle");
    AST_START_SCB: assert property (ru_start &&
        ru_state == rdw_pkg::RU_IDLE |-> ##[1:8]
        mem_req && !mem_we && mem_addr == 24'h000006)
        else $error("start did not read the control block");
    AST_SUSP_HOLD: assert property (parked_s ##0
        !ru_resume && !ru_start |=> parked_s)
        else $error("left suspend without resume");
    AST_SUSP_QUIET: assert property (parked_s |-> !mem_req)
        else $error("memory traffic while suspended");
    AST_RESUME: assert property (parked_s ##0 ru_resume |->
        ##[1:4] ru_state != rdw_pkg::RU_SUSPENDED)
        else $error("resume ignored");
    AST_BYTE_COPY: assert property (mem_req && mem_we &&
        mem_be != 2'b11 |-> mem_wdata[15:8] == mem_wdata[7:0])
        else $error("byte write not replicated");
    AST_BYTE_LANE: assert property (mem_req && mem_we &&
        mem_be != 2'b11 |-> mem_be == {mem_addr[0], !mem_addr[0]})
        else $error("byte lane does not match address");
    AST_WORD_EVEN: assert property (mem_req && mem_we &&
        mem_be == 2'b11 |-> !mem_addr[0])
        else $error("word write at odd address");
endmodule

// ### verification/receive_descriptor_writeback_tb.sv
/* Bench: receive unit and host end joined by the link, APB master,
   byte source and a memory model. Assumes package memory layout. */
`timescale 1ns/100ps
module receive_descriptor_writeback_tb;
    `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
        fail_count++; $display("wrong value at %0t: got %h exp %h", \
        $time, a, e); end end
    logic clk_sys_i = 0;
    logic reset_i = 1;
    logic psel = 0, penable = 0, pwrite = 0, er, pready, pslverr;
    logic [7:0] paddr = 0, rx_data = 0;
    logic [31:0] pwdata = 0, rd, prdata;
    logic rx_valid = 0, rx_last = 0, bs = 0, rx_ready;
    logic [4:0] err = 0;
    logic [15:0] ew [int];
    int rq[$] = '{40, 48};
    int tbl[$] = '{3, 'h10, 8, 0, 9, 0, 10, 'h30, 11, 'h50, 24, 0,
        25, 'hc000, 26, 'h10, 27, 'h60, 40, 0, 41, 'h60, 42, 'h100,
        43, 0, 44, 4, 48, 0, 49, 'h50, 50, 'h120, 51, 0, 52, 'h8008};
    int fail_count = 0, comparisons = 0, cnt = 0, i;
    rdw_link_if link ();

    // Both ends and the checker
    rdw_dev rdw_dev_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .link(link.dev), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
        .rx_last_i(rx_last), .rx_ready_o(rx_ready),
        .rx_crc_err_i(err[4]), .rx_align_err_i(err[3]),
        .rx_overrun_i(err[2]), .rx_short_i(err[1]),
        .rx_no_end_i(err[0]), .cfg_bitstuff_i(bs));
    rdw_host rdw_host_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .link(link.host), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
    rdw_properties rdw_properties_inst (.clk_sys_i(clk_sys_i),
        .reset_i(reset_i), .mem_req(link.mem_req), .mem_we(link.mem_we),
        .mem_addr(link.mem_addr), .mem_be(link.mem_be),
        .mem_wdata(link.mem_wdata), .mem_ack(link.mem_ack),
        .mem_rdata(link.mem_rdata), .ru_start(link.ru_start),
        .ru_resume(link.ru_resume), .ru_state(link.ru_state));

    // Clock, 8 ns period
    always #4 clk_sys_i = ~clk_sys_i;

    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys_i);
    endtask

    // Memory word write, mirrored in the model
    task wr(input int w, input logic [15:0] v);
        apb(1, rdw_pkg::REG_MADDR, w);
        apb(1, rdw_pkg::REG_MDATA, {16'h0000, v});
        ew[w] = v;
    endtask

    // Memory word read against the model
    task cmpw(input int w);
        apb(1, rdw_pkg::REG_MADDR, w);
        apb(0, rdw_pkg::REG_MDATA, 0);
        `CHK(rd[15:0], ew[w])
    endtask

    // One byte, held until taken
    task send(input logic [7:0] d, input logic l);
        rx_data <= d;
        rx_last <= l;
        rx_valid <= 1;
        do @(posedge clk_sys_i); while (rx_ready !== 1'b1);
    endtask

    // Frame of 14 header bytes and nd data bytes, model updated
    task automatic rx_frame(input int fd, input int nd,
        input logic [4:0] e, input logic b);
        int a, k, fr;
        logic [7:0] d;
        fr = 'hffff;
        err <= e;
        bs <= b;
        for (k = 0; k < 14 + nd; k++) begin
            d = 8'($urandom);
            a = fd + 8 + k;
            if (k >= 14) begin
                if (k == 14) fr = 2 * rq[0];
                a = ew[rq[0] + 2] + cnt;
                cnt++;
            end
            ew[a / 2][8 * (a % 2) +: 8] = d;
            send(d, k == 13 + nd);
            if (k >= 14 && cnt == ew[rq[0] + 4][13:0]) begin
                ew[rq[0]] = {2'b01, 14'(cnt)};
                void'(rq.pop_front());
                cnt = 0;
            end
        end
        rx_valid <= 0;
        @(posedge clk_sys_i);
        if (nd > 0) ew[rq[0]] = {2'b11, 14'(cnt)};
        ew[fd / 2 + 3] = 16'(fr);
        ew[fd / 2] = (e[4:1] == 0 && !(e[0] & b)) ? 16'he000 :
            {4'hc, e[4], e[3], 1'b0, e[2], e[1], e[0] & b, 6'h00};
    endtask

    // Poll unit state over APB
    task waitst(input logic [1:0] v);
        int n;
        n = 0;
        do begin
            apb(0, rdw_pkg::REG_STATUS, 0);
            n++;
        end while (rd[1:0] !== v && n < 300);
        `CHK(rd[1:0], v)
    endtask

    // Counts and verdict
    task finish_test;
        $display("counts: %0d compared, %0d wrong", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail_count++;
        finish_test;
    end

    // Main sequence
    initial begin
        void'($urandom(32'h551b7bea));
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 0;
        @(posedge clk_sys_i);
        apb(0, 8'h10, 0);
        `CHK({er, rd}, 33'h100000000)
        for (i = 0; i < tbl.size(); i += 2) wr(tbl[i], tbl[i + 1]);
        $display("test setup done");
        apb(1, rdw_pkg::REG_CTRL, 1);
        rx_frame('h10, 6, 5'b00001, 0);
        rx_frame('h30, 0, 5'b11111, 1);
        waitst(rdw_pkg::RU_SUSPENDED);
        cmpw(8);
        cmpw(24);
        cmpw(11);
        cmpw(27);
        cmpw(40);
        cmpw(48);
        foreach (ew[j]) cmpw(j);
        $display("test frames done");
        apb(1, rdw_pkg::REG_CTRL, 2);
        waitst(rdw_pkg::RU_IDLE);
        $display("test resume done");
        finish_test;
    end
endmodule
